// ---- door_rev_pkg.sv ----
// constants, encodings and register map of the closing reversal manager
package door_rev_pkg;

   // clock and reversal hold time
   localparam int CLK_HZ  = 40_000_000;
   localparam int HOLD_MS = 500;
   localparam int HOLD_CYCLES_DEF = (CLK_HZ / 1000) * HOLD_MS;
   localparam int TW = 25;

   // forces in units of 0.1 N
   localparam int FW = 16;
   localparam logic [FW-1:0] F_STEP_UP   = 16'h003c;
   localparam logic [FW-1:0] F_STEP_DN   = 16'h0001;
   localparam logic [FW-1:0] F_SET_RST   = 16'h0514;
   localparam logic [FW-1:0] F_FLOOR_RST = 16'h044c;
   localparam logic [FW-1:0] F_CEIL_RST  = 16'h05dc;
   localparam logic [FW-1:0] F_FLOOR_MIN = 16'h0320;
   localparam logic [FW-1:0] F_MOTOR_DEF = 16'h07d0;

   // end-of-closing offset: percent setting, 0.1 mm per step of limit
   localparam logic [7:0]         OFS_RST   = 8'h6e;
   localparam logic signed [15:0] OFS_MID   = 16'sh0064;
   localparam logic signed [15:0] OFS_SCALE = 16'sh0002;

   typedef enum logic [1:0]
   {
      MODE_AUTO     = 2'b00,
      MODE_EXT_MOVE = 2'b01,
      MODE_EXT_PARK = 2'b10
   } rev_mode_e;

   typedef enum logic [1:0]
   {
      OUT_UNTIL_OPEN   = 2'b00,
      OUT_UNTIL_REOPEN = 2'b01,
      OUT_PULSE        = 2'b10
   } out_type_e;

   typedef enum logic [2:0]
   {
      S_IDLE   = 3'b000,
      S_AUTO   = 3'b001,
      S_WAIT   = 3'b010,
      S_REOPEN = 3'b011,
      S_SLOW   = 3'b100
   } rev_state_e;

   // register byte addresses
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_FLOOR  = 8'h04;
   localparam logic [7:0] A_CEIL   = 8'h08;
   localparam logic [7:0] A_SETPT  = 8'h0c;
   localparam logic [7:0] A_OFFSET = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_ISTAT  = 8'h18;
   localparam logic [7:0] A_IMASK  = 8'h1c;

   // control fields and reset values
   localparam int C_MODE_LSB = 0;
   localparam int C_TYPE_LSB = 2;
   localparam int C_TUNE_BIT = 4;
   localparam logic [1:0] MODE_RST = 2'b00;
   localparam logic [1:0] TYPE_RST = 2'b01;
   localparam logic       TUNE_RST = 1'b1;

   // interrupt bits
   localparam int IW = 3;
   localparam int I_REV  = 0;
   localparam int I_WARN = 1;
   localparam int I_FORC = 2;

endpackage

// ---- door_reversal.sv ----
// closing reversal manager: triggers, reversing indication, force limit, wishbone registers
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - mode 00: reopen automatically, assert indication
// - mode 01: halt, indicate, await controller command
// - mode 02: also refuse closing when parked blocked
// - no open command in 0.5s: slow close, warn
// - type 00: indication until open command
// - type 01: indication until reopening finished
// - type 02: indication pulse of 0.5s
// - types 00/02 ignored in automatic mode
// - obstacle raises threshold 6N up to ceiling
// - clean closing lowers threshold 0.1N to floor
// - tuning off: threshold changes only on setpoint write
// - obstacle when force exceeds threshold; defaults
// - floor accepted from 80N to ceiling
// - force limiter masked near closed position
// - offset spans -20mm to +20mm
module door_reversal
   import door_rev_pkg::*;
#(
   parameter int            HOLD_CYCLES = HOLD_CYCLES_DEF,
   parameter logic [FW-1:0] MOTOR_MAX   = F_MOTOR_DEF
)
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // wishbone slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [31:0]   wb_dat_i,
   input  wire logic [3:0]    wb_sel_i,
   output var  logic [31:0]   wb_dat_o,
   output var  logic          wb_ack_o,
   // pins from the safety source and the lift main controller
   input  wire logic          ext_reverse_pin,
   input  wire logic          open_command_input,
   // drive state, same clock
   input  wire logic          closing_active,
   input  wire logic          opening_active,
   input  wire logic          parked_open,
   input  wire logic          reopen_done,
   input  wire logic          closing_done,
   input  wire logic [FW-1:0] closing_force,
   input  wire logic [15:0]   door_pos,
   // requests to the motion logic
   output var  logic          reopen_req,
   output var  logic          halt_req,
   output var  logic          slow_close_req,
   output var  logic          close_refuse,
   output var  logic          force_limiter_active,
   // indications
   output var  logic          reversing_indication_output,
   output var  logic          missing_reopen_warning,
   output var  logic          irq
);

   function automatic logic signed [15:0] mask_limit(input logic [7:0] pct);
      logic signed [15:0] d;
      logic signed [31:0] p;
      d = signed'({8'h00, pct}) - OFS_MID;
      p = d * OFS_SCALE;
      return p[15:0];
   endfunction

   // reset release and pin synchronisers
   logic       rst_meta_reg;
   logic       rst_n;
   logic [1:0] ext_sync_reg;
   logic [1:0] open_sync_reg;
   logic       ext_s;
   logic       open_s;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_sync_reg  <= 2'b00;
         open_sync_reg <= 2'b00;
      end
      else
      begin
         ext_sync_reg  <= {ext_sync_reg[0], ext_reverse_pin};
         open_sync_reg <= {open_sync_reg[0], open_command_input};
      end
   end
   assign ext_s  = ext_sync_reg[1];
   assign open_s = open_sync_reg[1];

   // configuration registers
   logic [1:0]    mode_reg;
   logic [1:0]    type_reg;
   logic          tune_reg;
   logic [FW-1:0] floor_reg;
   logic [FW-1:0] ceil_reg;
   logic [7:0]    ofs_reg;
   logic [IW-1:0] istat_reg;
   logic [IW-1:0] imask_reg;
   logic          wr_go;
   logic          rd_go;

   assign wr_go = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_sel_i != 4'h0);
   assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o;

   force_tune_if tune ();

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_reg  <= MODE_RST;
         type_reg  <= TYPE_RST;
         tune_reg  <= TUNE_RST;
         floor_reg <= F_FLOOR_RST;
         ceil_reg  <= F_CEIL_RST;
         ofs_reg   <= OFS_RST;
         imask_reg <= '0;
      end
      else if (wr_go)
      begin
         case (wb_adr_i)
            A_CTRL:
            begin
               mode_reg <= wb_dat_i[C_MODE_LSB +: 2];
               type_reg <= wb_dat_i[C_TYPE_LSB +: 2];
               tune_reg <= wb_dat_i[C_TUNE_BIT];
            end
            A_FLOOR:
               if (wb_dat_i[FW-1:0] >= F_FLOOR_MIN && wb_dat_i[FW-1:0] <= ceil_reg)
                  floor_reg <= wb_dat_i[FW-1:0];
            A_CEIL:
               if (wb_dat_i[FW-1:0] >= floor_reg && wb_dat_i[FW-1:0] <= MOTOR_MAX)
                  ceil_reg <= wb_dat_i[FW-1:0];
            A_OFFSET:
               if (wb_dat_i[7:0] <= 8'(2 * OFS_MID))
                  ofs_reg <= wb_dat_i[7:0];
            A_IMASK:
               imask_reg <= wb_dat_i[IW-1:0];
            default:
               ;
         endcase
      end
   end

   // obstacle detection and trigger
   rev_state_e         state_reg;
   rev_state_e         state_next;
   logic               force_act;
   logic               force_trip;
   logic               trig;
   logic               park_block;
   logic               seen_reg;
   logic [TW-1:0]      wait_cnt;
   logic [TW-1:0]      pulse_cnt;
   logic               ind_reg;
   logic               ind_next;
   logic               ind_clr;
   out_type_e          eff_type;

   assign force_act  = closing_active && (signed'(door_pos) > mask_limit(ofs_reg));
   assign force_trip = force_act && (closing_force > tune.threshold);
   assign trig       = (state_reg == S_IDLE) && closing_active && !opening_active
                       && (ext_s || force_trip);
   assign park_block = (mode_reg == MODE_EXT_PARK) && parked_open && ext_s;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         seen_reg <= 1'b0;
      else if (closing_done || reopen_done)
         seen_reg <= 1'b0; // closing or reopening is over, next one starts clean
      else if (force_trip || trig)
         seen_reg <= 1'b1;
   end

   assign tune.obstacle    = trig && force_trip;
   assign tune.clean_close = closing_done && !seen_reg && (state_reg == S_IDLE);
   assign tune.autotune_en = tune_reg;
   assign tune.set_wr      = wr_go && (wb_adr_i == A_SETPT);
   assign tune.set_val     = wb_dat_i[FW-1:0];
   assign tune.floor_val   = floor_reg;
   assign tune.ceil_val    = ceil_reg;

   force_tuner u_tuner
   (
      .clk   (clk),
      .rst_n (rst_n),
      .t     (tune.tuner)
   );

   // reversal sequence
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE:
            if (trig)
               state_next = (mode_reg == MODE_AUTO) ? S_AUTO : S_WAIT;
         S_AUTO:
            if (reopen_done)
               state_next = S_IDLE;
         S_WAIT:
            if (open_s)
               state_next = S_REOPEN;
            else if (wait_cnt == TW'(HOLD_CYCLES - 1))
               state_next = S_SLOW;
         S_REOPEN:
            if (reopen_done)
               state_next = S_IDLE;
         S_SLOW:
            if (open_s)
               state_next = S_REOPEN;
            else if (closing_done)
               state_next = S_IDLE;
         default:
            state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wait_cnt <= '0;
      else if (state_reg == S_WAIT)
         wait_cnt <= wait_cnt + 1'b1;
      else
         wait_cnt <= '0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg              <= S_IDLE;
         reopen_req             <= 1'b0;
         halt_req               <= 1'b0;
         slow_close_req         <= 1'b0;
         missing_reopen_warning <= 1'b0;
      end
      else
      begin
         state_reg              <= state_next;
         reopen_req             <= (state_next == S_AUTO) || (state_next == S_REOPEN);
         halt_req               <= (state_next == S_WAIT);
         slow_close_req         <= (state_next == S_SLOW);
         missing_reopen_warning <= (state_reg == S_WAIT) && (state_next == S_SLOW);
      end
   end

   // reversing indication
   assign eff_type = (mode_reg == MODE_AUTO || type_reg == 2'b11) ? OUT_UNTIL_REOPEN
                     : out_type_e'(type_reg);

   always_comb
   begin
      case (eff_type)
         OUT_UNTIL_OPEN:
            ind_clr = open_s;
         OUT_PULSE:
            ind_clr = (pulse_cnt == TW'(HOLD_CYCLES - 1));
         default:
            ind_clr = (state_reg != S_IDLE) && (state_next == S_IDLE);
      endcase
      ind_next = trig || (ind_reg && !ind_clr);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pulse_cnt <= '0;
      else if (trig || !ind_reg)
         pulse_cnt <= '0;
      else
         pulse_cnt <= pulse_cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ind_reg                     <= 1'b0;
         reversing_indication_output <= 1'b0;
         close_refuse                <= 1'b0;
         force_limiter_active        <= 1'b0;
      end
      else
      begin
         ind_reg                     <= ind_next;
         reversing_indication_output <= ind_next || park_block;
         close_refuse                <= park_block;
         force_limiter_active        <= force_act;
      end
   end

   // interrupts: sticky events, write one to clear, set wins
   logic [IW-1:0] ev;
   logic [IW-1:0] clr;
   assign ev  = {tune.obstacle, (state_reg == S_WAIT) && (state_next == S_SLOW), trig};
   assign clr = (wr_go && wb_adr_i == A_ISTAT) ? wb_dat_i[IW-1:0] : '0;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         istat_reg <= '0;
         irq       <= 1'b0;
      end
      else
      begin
         istat_reg <= ev | (istat_reg & ~clr);
         irq       <= |((ev | (istat_reg & ~clr)) & imask_reg);
      end
   end

   // bus answer: one wait state, unmapped reads return zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= rd_go;
         if (rd_go)
         begin
            case (wb_adr_i)
               A_CTRL:   wb_dat_o <= {27'h0, tune_reg, type_reg, mode_reg};
               A_FLOOR:  wb_dat_o <= {16'h0, floor_reg};
               A_CEIL:   wb_dat_o <= {16'h0, ceil_reg};
               A_SETPT:  wb_dat_o <= {16'h0, tune.threshold};
               A_OFFSET: wb_dat_o <= {24'h0, ofs_reg};
               A_STATUS: wb_dat_o <= {tune.threshold, 9'h0, state_reg, 2'h0, park_block, ind_reg};
               A_ISTAT:  wb_dat_o <= {29'h0, istat_reg};
               A_IMASK:  wb_dat_o <= {29'h0, imask_reg};
               default:  wb_dat_o <= '0;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_auto;
      trig && mode_reg == MODE_AUTO |=> reopen_req && !halt_req ##1 reversing_indication_output;
   endproperty
   a_auto: assert property (p_auto) else $error("auto mode did not reopen");

   property p_halt;
      trig && mode_reg != MODE_AUTO |=> halt_req && !reopen_req ##1 reversing_indication_output;
   endproperty
   a_halt: assert property (p_halt) else $error("external mode did not halt");

   property p_park;
      park_block |=> close_refuse && reversing_indication_output;
   endproperty
   a_park: assert property (p_park) else $error("parked block not refused");

   property p_timeout;
      state_reg == S_WAIT && !open_s && wait_cnt == TW'(HOLD_CYCLES - 1)
         |=> slow_close_req && missing_reopen_warning ##1 !missing_reopen_warning;
   endproperty
   a_timeout: assert property (p_timeout) else $error("no slow close after hold");

   property p_open_ends;
      state_reg != S_IDLE && eff_type == OUT_UNTIL_OPEN && open_s && !park_block
         |=> ##1 !reversing_indication_output;
   endproperty
   a_open_ends: assert property (p_open_ends) else $error("indication outlived open cmd");

   property p_reopen_ends;
      (state_reg == S_AUTO || state_reg == S_REOPEN) && eff_type == OUT_UNTIL_REOPEN
         && reopen_done |=> !ind_reg;
   endproperty
   a_reopen_ends: assert property (p_reopen_ends) else $error("indication outlived reopen");

   property p_pulse;
      eff_type == OUT_PULSE && ind_reg && pulse_cnt == TW'(HOLD_CYCLES - 1) |=> !ind_reg;
   endproperty
   a_pulse: assert property (p_pulse) else $error("indication pulse too long");

   property p_auto_type;
      mode_reg == MODE_AUTO && state_reg == S_AUTO && ind_reg && !reopen_done
         && $stable(mode_reg) |=> ind_reg;
   endproperty
   a_auto_type: assert property (p_auto_type) else $error("auto mode used output type");

   property p_trip;
      state_reg == S_IDLE && force_act && !opening_active && closing_force > tune.threshold
         |=> state_reg != S_IDLE;
   endproperty
   a_trip: assert property (p_trip) else $error("force over threshold ignored");

   property p_floor;
      wr_go && wb_adr_i == A_FLOOR && wb_dat_i[FW-1:0] < F_FLOOR_MIN |=> $stable(floor_reg);
   endproperty
   a_floor: assert property (p_floor) else $error("floor below minimum taken");

   property p_mask;
      closing_active && signed'(door_pos) <= mask_limit(ofs_reg) |-> !force_trip;
   endproperty
   a_mask: assert property (p_mask) else $error("force limiter active in end zone");

   property p_opening;
      state_reg == S_IDLE && opening_active |=> state_reg == S_IDLE;
   endproperty
   a_opening: assert property (p_opening) else $error("trigger acted while opening");

   c_auto:    cover property (trig && mode_reg == MODE_AUTO);
   c_wait_ok: cover property (state_reg == S_WAIT && open_s);
   c_slow:    cover property (state_reg == S_WAIT ##1 state_reg == S_SLOW);
   c_park:    cover property (park_block);

endmodule
`default_nettype wire

// ---- door_reversal_tb_top.sv ----
// self-checking bench for the closing reversal manager
`timescale 1ns/100ps
`default_nettype none
module door_reversal_tb_top;
   import door_rev_pkg::*;
   localparam int HOLD = 50;
   logic clk = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [3:0] wb_sel_i = 4'hf;
   logic wb_ack_o, ext_reverse_pin = 1'b0, open_command_input;
   logic closing_active = 1'b0, opening_active = 1'b0, parked_open = 1'b0;
   logic reopen_done = 1'b0, closing_done = 1'b0;
   logic [FW-1:0] closing_force = 16'h0;
   logic [15:0] door_pos = 16'h0;
   logic reopen_req, halt_req, slow_close_req, close_refuse, force_limiter_active;
   logic reversing_indication_output, missing_reopen_warning, irq;
   int n_mismatch = 0, checked = 0, cycles = 0, delay = 0, cnt = 0;
   logic [31:0] expq[$];

   door_reversal #(.HOLD_CYCLES(HOLD), .MOTOR_MAX(F_MOTOR_DEF)) DUT
   (
      .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_dat_o, .wb_ack_o, .ext_reverse_pin, .open_command_input, .closing_active,
      .opening_active, .parked_open, .reopen_done, .closing_done, .closing_force,
      .door_pos, .reopen_req, .halt_req, .slow_close_req, .close_refuse,
      .force_limiter_active, .reversing_indication_output, .missing_reopen_warning, .irq
   );
   lift_ctrl_model ctrl_model
   (
      .clk, .rstn, .rev_ind(reversing_indication_output), .delay, .open_cmd(open_command_input)
   );

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic pulse(input logic ro);
      @(posedge clk);
      reopen_done <= ro;
      closing_done <= !ro;
      @(posedge clk);
      reopen_done <= 1'b0;
      closing_done <= 1'b0;
   endtask

   // read results are compared when the ack appears
   always @(posedge clk)
   begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0)
         check(wb_dat_o, expq.pop_front());
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         final_report();
      end
   end

   initial
   begin
      void'($urandom(32'hd40d));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      tick(4);
      rd(A_CTRL, 32'h14);
      rd(A_FLOOR, {16'h0, F_FLOOR_RST});
      rd(A_CEIL, {16'h0, F_CEIL_RST});
      rd(A_SETPT, {16'h0, F_SET_RST});
      rd(A_OFFSET, {24'h0, OFS_RST});
      wb(1'b1, A_FLOOR, 32'h31f);
      wb(1'b1, 8'h40, 32'hffff);
      rd(A_FLOOR, {16'h0, F_FLOOR_RST});
      rd(8'h40, 32'h0);
      wb(1'b1, A_IMASK, 32'h7);
      $display("test registers done");
      // automatic mode, type 00 must act as 01; obstacle masked in end zone first
      wb(1'b1, A_CTRL, 32'h10);
      wb(1'b1, A_OFFSET, 32'hc8);
      delay = 8;
      closing_active <= 1'b1;
      door_pos <= 16'h00c8;
      closing_force <= F_SET_RST + 16'h1 + 16'($urandom_range(200));
      tick(4);
      check(force_limiter_active, 1'b0);
      check(reopen_req, 1'b0);
      door_pos <= 16'h00c9 + 16'($urandom_range(1000));
      while (reopen_req !== 1'b1) @(posedge clk);
      tick(1);
      check(halt_req, 1'b0);
      check(reversing_indication_output, 1'b1);
      check(irq, 1'b1);
      check(force_limiter_active, 1'b1);
      closing_active <= 1'b0;
      closing_force <= 16'h0;
      rd(A_SETPT, {16'h0, F_SET_RST + F_STEP_UP});
      rd(A_ISTAT, 32'h5);
      tick(10);
      check(reversing_indication_output, 1'b1);
      pulse(1'b1);
      tick(2);
      check(reversing_indication_output, 1'b0);
      wb(1'b1, A_ISTAT, 32'h7);
      tick(2);
      check(irq, 1'b0);
      closing_active <= 1'b1;
      tick(3);
      pulse(1'b0);
      closing_active <= 1'b0;
      rd(A_SETPT, {16'h0, F_SET_RST + F_STEP_UP - F_STEP_DN});
      $display("test automatic reopen done");
      // halt mode, indication until open command, prompt controller
      wb(1'b1, A_CTRL, 32'h11);
      delay = 8;
      closing_active <= 1'b1;
      ext_reverse_pin <= 1'b1;
      while (halt_req !== 1'b1) @(posedge clk);
      check(reopen_req, 1'b0);
      closing_active <= 1'b0;
      ext_reverse_pin <= 1'b0;
      while (reopen_req !== 1'b1) @(posedge clk);
      tick(2);
      check(slow_close_req, 1'b0);
      check(reversing_indication_output, 1'b0);
      pulse(1'b1);
      $display("test halt and reopen done");
      // halt mode, pulse indication, controller never answers
      wb(1'b1, A_CTRL, 32'h19);
      delay = 0;
      closing_active <= 1'b1;
      ext_reverse_pin <= 1'b1;
      while (halt_req !== 1'b1) @(posedge clk);
      check(reversing_indication_output, 1'b1);
      ext_reverse_pin <= 1'b0;
      closing_active <= 1'b0;
      cnt = 0;
      while (slow_close_req !== 1'b1)
      begin
         @(posedge clk);
         cnt++;
      end
      check(missing_reopen_warning, 1'b1);
      check(32'(cnt >= HOLD - 2 && cnt <= HOLD + 1), 32'h1);
      tick(3);
      check(reversing_indication_output, 1'b0);
      pulse(1'b0);
      $display("test missing reopen done");
      // parked open block
      wb(1'b1, A_CTRL, 32'h16);
      parked_open <= 1'b1;
      ext_reverse_pin <= 1'b1;
      tick(5);
      check(close_refuse, 1'b1);
      check(reversing_indication_output, 1'b1);
      ext_reverse_pin <= 1'b0;
      tick(5);
      check(close_refuse, 1'b0);
      parked_open <= 1'b0;
      $display("test parked block done");
      // tuning off, triggers ignored while opening
      wb(1'b1, A_CTRL, 32'h0);
      opening_active <= 1'b1;
      closing_active <= 1'b1;
      closing_force <= 16'hffff;
      door_pos <= 16'h1000;
      tick(5);
      check(reopen_req, 1'b0);
      opening_active <= 1'b0;
      while (reopen_req !== 1'b1) @(posedge clk);
      closing_active <= 1'b0;
      closing_force <= 16'h0;
      pulse(1'b1);
      rd(A_SETPT, {16'h0, F_SET_RST + F_STEP_UP - F_STEP_DN});
      wb(1'b1, A_SETPT, 32'hffff);
      rd(A_SETPT, {16'h0, F_CEIL_RST});
      $display("test tuning off done");
      final_report();
   end
endmodule
`default_nettype wire

// ---- force_tune_if.sv ----
// signals between the reversal manager and its force threshold tuner
`timescale 1ns/100ps
`default_nettype none
interface force_tune_if;
   import door_rev_pkg::*;
   logic          obstacle;
   logic          clean_close;
   logic          autotune_en;
   logic          set_wr;
   logic [FW-1:0] set_val;
   logic [FW-1:0] floor_val;
   logic [FW-1:0] ceil_val;
   logic [FW-1:0] threshold;
   modport mgr   (output obstacle, clean_close, autotune_en, set_wr, set_val, floor_val,
                  ceil_val, input threshold);
   modport tuner (input obstacle, clean_close, autotune_en, set_wr, set_val, floor_val,
                  ceil_val, output threshold);
endinterface
`default_nettype wire

// ---- force_tuner.sv ----
// closing force threshold with auto-tuning between floor and ceiling
`timescale 1ns/100ps
`default_nettype none
module force_tuner
   import door_rev_pkg::*;
(
   // clock and synchronised reset
   input wire logic   clk,
   input wire logic   rst_n,
   // manager side
   force_tune_if.tuner t
);

   function automatic logic [FW-1:0] clamp(input logic [FW:0] v, input logic [FW-1:0] lo,
                                           input logic [FW-1:0] hi);
      logic [FW-1:0] r;
      r = v[FW-1:0];
      if (v > {1'b0, hi})
         r = hi;
      else if (v < {1'b0, lo})
         r = lo;
      return r;
   endfunction

   logic [FW-1:0] thr_reg;
   assign t.threshold = thr_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         thr_reg <= F_SET_RST;
      else if (t.set_wr)
         thr_reg <= clamp({1'b0, t.set_val}, t.floor_val, t.ceil_val);
      else if (t.autotune_en && t.obstacle)
         thr_reg <= clamp({1'b0, thr_reg} + {1'b0, F_STEP_UP}, F_STEP_DN, t.ceil_val);
      else if (t.autotune_en && t.clean_close && thr_reg > t.floor_val)
         thr_reg <= thr_reg - F_STEP_DN;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_step_up;
      !t.set_wr && t.autotune_en && t.obstacle && thr_reg + F_STEP_UP <= t.ceil_val
         |=> thr_reg == $past(thr_reg) + F_STEP_UP;
   endproperty
   a_step_up: assert property (p_step_up) else $error("threshold did not rise by step");

   property p_step_dn;
      !t.set_wr && t.autotune_en && !t.obstacle && t.clean_close && thr_reg > t.floor_val
         |=> thr_reg == $past(thr_reg) - F_STEP_DN;
   endproperty
   a_step_dn: assert property (p_step_dn) else $error("threshold did not fall by step");

   property p_frozen;
      !t.set_wr && !t.autotune_en |=> $stable(thr_reg);
   endproperty
   a_frozen: assert property (p_frozen) else $error("threshold changed with tuning off");

endmodule
`default_nettype wire

// ---- lift_ctrl_model.sv ----
// lift main controller model: answers the reversing indication with an open command
`timescale 1ns/100ps
`default_nettype none
module lift_ctrl_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // door drive side; delay 0 means never answer
   input  wire logic        rev_ind,
   input  wire logic [31:0] delay,
   output var  logic        open_cmd
);
   int cnt;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn || !rev_ind)
      begin
         cnt <= 0;
         open_cmd <= 1'b0;
      end
      else if (delay > 0 && cnt == delay)
         open_cmd <= 1'b1;
      else
         cnt <= cnt + 1;
   end
endmodule
`default_nettype wire
